// *** verilog/jtag_isp_port_control.sv ***
// test port pin control, tap and programming command gate
//
// Functional notes
// - pins enabled by nvm, register or term
// - disabled pins stay general purpose io
// - pins inputs; data out after enable
// - extension pins only when enable requests
// - nvm bit dedicates pins permanently
// - run enable register at c7h
// - product term may enable pins
// - programming commands only, no boundary scan
// - error pin low on flash failure
// - error held until clear or reset
// - status high when flash readable
// - status low while program/erase/write busy
// - open-drain option for extension pins
// - secured: only chip erase allowed
// - chip erase clears security
// - protected sectors refuse erase
// - port e bit mapping of signals
// - reset aborts flash cycle within 25us
// - all targets programmable over port
`timescale 1ns/10ps
`default_nettype none
`include "jtag_isp_consts.svh"

module jtag_isp_port_control import jtag_isp_pkg::*; (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        tck_i,
  input  wire logic        mcu_io_sel_i,
  input  wire logic [7:0]  mcu_addr_i,
  input  wire logic        mcu_wr_i,
  input  wire logic        mcu_rd_i,
  input  wire logic [7:0]  mcu_wdata_i,
  output logic      [7:0]  mcu_rdata_o,
  input  wire logic        nvm_test_dedicate_i,
  input  wire logic        test_select_term_i,
  input  wire logic        security_bit_i,
  input  wire logic [11:0] sector_protect_i,
  output logic             flash_req_o,
  output isc_op_type       flash_op_o,
  output logic      [1:0]  flash_target_o,
  output logic      [19:0] flash_addr_o,
  output logic      [7:0]  flash_wdata_o,
  input  wire logic        flash_done_i,
  input  wire logic        flash_fail_i,
  input  wire logic [7:0]  flash_rdata_i,
  input  wire logic        flash_busy_i,
  output logic             flash_abort_o,
  input  wire logic [5:0]  port_e_in_i,
  output logic      [5:0]  port_e_out_o,
  output logic      [5:0]  port_e_oe_o,
  input  wire logic [5:0]  gpio_out_i,
  input  wire logic [5:0]  gpio_oe_i,
  output logic      [5:0]  gpio_in_o,
  output logic             test_pins_on_o
);

  // ---
  // helpers
  // ---
  function automatic isc_op_type ir_to_op(input logic [3:0] ir);
    case (ir)
      `IR_PROGRAM:    return OP_PROGRAM;
      `IR_ERASE:      return OP_ERASE;
      `IR_CHIP_ERASE: return OP_CHIP_ERASE;
      `IR_READ:       return OP_READ;
      `IR_VERIFY:     return OP_VERIFY;
      default:        return OP_NONE;
    endcase
  endfunction

  function automatic tap_state_type tap_next(input tap_state_type s, input logic tms);
    case (s)
      TAP_RESET:    return tms ? TAP_RESET   : TAP_IDLE;
      TAP_IDLE:     return tms ? TAP_SEL_DR  : TAP_IDLE;
      TAP_SEL_DR:   return tms ? TAP_SEL_IR  : TAP_CAP_DR;
      TAP_CAP_DR:   return tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: return tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: return tms ? TAP_UPD_DR  : TAP_PAUSE_DR;
      TAP_PAUSE_DR: return tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: return tms ? TAP_UPD_DR  : TAP_SHIFT_DR;
      TAP_UPD_DR:   return tms ? TAP_SEL_DR  : TAP_IDLE;
      TAP_SEL_IR:   return tms ? TAP_RESET   : TAP_CAP_IR;
      TAP_CAP_IR:   return tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: return tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: return tms ? TAP_UPD_IR  : TAP_PAUSE_IR;
      TAP_PAUSE_IR: return tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: return tms ? TAP_UPD_IR  : TAP_SHIFT_IR;
      TAP_UPD_IR:   return tms ? TAP_SEL_DR  : TAP_IDLE;
      default:      return TAP_RESET;
    endcase
  endfunction

  // ---
  // run enable register
  // ---
  logic        run_en_q;
  logic        secure_q;
  logic        sec_loaded_q;
  logic        pins_on;
  logic [7:0]  rdata_q;

  assign pins_on        = nvm_test_dedicate_i | run_en_q | test_select_term_i;
  assign test_pins_on_o = pins_on;
  assign mcu_rdata_o    = rdata_q;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_en_q <= 1'b0;
    end else if (mcu_io_sel_i && mcu_wr_i && mcu_addr_i == `RUN_ENABLE_OFS) begin
      run_en_q <= mcu_wdata_i[`RUN_ENABLE_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= `RUN_ENABLE_RST;
    end else if (mcu_io_sel_i && mcu_rd_i && mcu_addr_i == `RUN_ENABLE_OFS) begin
      rdata_q                   <= 8'h00;
      rdata_q[`RUN_ENABLE_BIT]  <= run_en_q;
      rdata_q[`RUN_PINS_ON_BIT] <= pins_on;
      rdata_q[`RUN_SECURED_BIT] <= secure_q;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ---
  // synchronisers
  // ---
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  // {clear toggle, request toggle, open drain, ext enable, isc enabled}
  logic [4:0] lk_s1_q;
  logic [4:0] lk_s2_q;
  logic [1:0] tgl_s3_q;
  logic [4:0] lk_bits;
  logic       req_evt;
  logic       clr_evt;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
      lk_s1_q  <= 5'h00;
      lk_s2_q  <= 5'h00;
      tgl_s3_q <= 2'h0;
    end else begin
      pin_s1_q <= port_e_in_i;
      pin_s2_q <= pin_s1_q;
      lk_s1_q  <= lk_bits;
      lk_s2_q  <= lk_s1_q;
      tgl_s3_q <= lk_s2_q[4:3];
    end
  end

  assign gpio_in_o = pin_s2_q;
  assign req_evt   = lk_s2_q[3] ^ tgl_s3_q[0];
  assign clr_evt   = lk_s2_q[4] ^ tgl_s3_q[1];

  // ---
  // flash abort window
  // ---
  logic [8:0] abort_cnt_q;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      abort_cnt_q <= 9'(`ABORT_CYC);
    end else if (abort_cnt_q != 9'h000) begin
      abort_cnt_q <= abort_cnt_q - 9'h001;
    end
  end

  assign flash_abort_o = abort_cnt_q != 9'h000;

  // ---
  // command execution
  // ---
  exec_state_type ex_q;
  isc_op_type     lk_op_q;
  logic [31:0]    lk_operand_q;
  logic           flash_status_out;
  isc_op_type     op_q;
  logic [31:0]    operand_q;
  logic           done_tgl_q;
  logic           err_q;
  logic           refused_q;
  logic [7:0]     res_data_q;
  logic           refuse;
  logic           fail_now;

  always_comb begin
    refuse = 1'b0;
    if (secure_q && op_q != OP_CHIP_ERASE) begin
      refuse = 1'b1;
    end
    if (op_q == OP_ERASE && sector_protect_i[operand_q[3:0]]) begin
      refuse = 1'b1;
    end
    if (op_q == OP_NONE) begin
      refuse = 1'b1;
    end
  end

  assign fail_now = flash_fail_i || (flash_op_o == OP_VERIFY && flash_rdata_i != flash_wdata_o);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ex_q           <= EX_IDLE;
      flash_req_o    <= 1'b0;
      flash_op_o     <= OP_NONE;
      flash_target_o <= 2'h0;
      flash_addr_o   <= 20'h00000;
      flash_wdata_o  <= 8'h00;
      done_tgl_q     <= 1'b0;
      refused_q      <= 1'b0;
      res_data_q     <= 8'h00;
    end else begin
      flash_req_o <= 1'b0;
      case (ex_q)
        EX_IDLE: begin
          if (req_evt && !flash_abort_o) begin
            if (refuse) begin
              refused_q  <= 1'b1;
              res_data_q <= 8'h00;
              done_tgl_q <= ~done_tgl_q;
            end else begin
              refused_q      <= 1'b0;
              flash_req_o    <= 1'b1;
              flash_op_o     <= op_q;
              flash_target_o <= operand_q[29:28];
              flash_addr_o   <= operand_q[27:8];
              flash_wdata_o  <= operand_q[7:0];
              ex_q           <= EX_WAIT;
            end
          end
        end
        EX_WAIT: begin
          if (flash_done_i) begin
            res_data_q <= flash_rdata_i;
            done_tgl_q <= ~done_tgl_q;
            ex_q       <= EX_IDLE;
          end
        end
        default: ex_q <= EX_IDLE;
      endcase
    end
  end

  // operand words are held by the link until the done toggle returns
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_q      <= OP_NONE;
      operand_q <= 32'h00000000;
    end else if (ex_q == EX_IDLE) begin
      op_q      <= lk_op_q;
      operand_q <= lk_operand_q;
    end
  end

  // security strap is caught after release, then only chip erase clears it
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      secure_q     <= 1'b0;
      sec_loaded_q <= 1'b0;
    end else if (!sec_loaded_q) begin
      secure_q     <= security_bit_i;
      sec_loaded_q <= 1'b1;
    end else if (ex_q == EX_WAIT && flash_done_i && flash_op_o == OP_CHIP_ERASE && !flash_fail_i) begin
      secure_q <= 1'b0;
    end
  end

  // a failure in the same cycle as a clear keeps the flag set
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_q <= 1'b0;
    end else if ((ex_q == EX_WAIT && flash_done_i && fail_now) ||
                 (ex_q == EX_IDLE && req_evt && !flash_abort_o && refuse)) begin
      err_q <= 1'b1;
    end else if (clr_evt) begin
      err_q <= 1'b0;
    end
  end

  // ---
  // link domain: tap
  // ---
  logic          lrst_s1_q;
  logic          lrst_n_q;
  logic [1:0]    on_s_q;
  tap_state_type tap_q;
  logic [3:0]    ir_sh_q;
  logic [3:0]    ir_q;
  logic [31:0]   dr_sh_q;
  logic          byp_q;
  logic          tdo_q;
  logic          isc_en_q;
  logic          ext_en_q;
  logic          od_q;
  logic          req_tgl_q;
  logic          clr_tgl_q;
  logic [1:0]    done_s_q;
  logic          done_seen_q;
  logic          pending;
  logic          tms;
  logic          tdi;
  logic          tap_live;

  assign tms      = port_e_in_i[`PE_MODE_BIT];
  assign tdi      = port_e_in_i[`PE_DIN_BIT];
  assign tap_live = on_s_q[1];
  assign pending  = req_tgl_q ^ done_seen_q;
  assign lk_bits  = {clr_tgl_q, req_tgl_q, od_q, ext_en_q, isc_en_q};

  always_ff @(posedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lrst_s1_q <= 1'b0;
      lrst_n_q  <= 1'b0;
    end else begin
      lrst_s1_q <= 1'b1;
      lrst_n_q  <= lrst_s1_q;
    end
  end

  always_ff @(posedge tck_i or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      on_s_q      <= 2'h0;
      done_s_q    <= 2'h0;
      done_seen_q <= 1'b0;
    end else begin
      on_s_q      <= {on_s_q[0], pins_on};
      done_s_q    <= {done_s_q[0], done_tgl_q};
      done_seen_q <= done_s_q[1];
    end
  end

  always_ff @(posedge tck_i or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      tap_q <= TAP_RESET;
    end else if (tap_live) begin
      tap_q <= tap_next(tap_q, tms);
    end
  end

  always_ff @(posedge tck_i or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      ir_sh_q <= 4'h0;
      ir_q    <= `IR_BYPASS;
      dr_sh_q <= 32'h00000000;
      byp_q   <= 1'b0;
    end else if (tap_live) begin
      case (tap_q)
        TAP_RESET:    ir_q    <= `IR_BYPASS;
        TAP_CAP_IR:   ir_sh_q <= `IR_CAPTURE;
        TAP_SHIFT_IR: ir_sh_q <= {tdi, ir_sh_q[3:1]};
        TAP_UPD_IR:   ir_q    <= ir_sh_q;
        TAP_CAP_DR: begin
          byp_q   <= 1'b0;
          dr_sh_q <= {20'h00000, pending, refused_q, ~flash_status_out, err_q, res_data_q};
        end
        TAP_SHIFT_DR: begin
          byp_q   <= tdi;
          dr_sh_q <= {tdi, dr_sh_q[31:1]};
        end
        default: ;
      endcase
    end
  end

  // the result byte is stable while nothing is pending; the error and busy bits can still change
  always_ff @(posedge tck_i or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      isc_en_q     <= 1'b0;
      ext_en_q     <= 1'b0;
      od_q         <= 1'b0;
      req_tgl_q    <= 1'b0;
      clr_tgl_q    <= 1'b0;
      lk_op_q      <= OP_NONE;
      lk_operand_q <= 32'h00000000;
    end else if (tap_live && tap_q == TAP_UPD_DR) begin
      case (ir_q)
        `IR_ISC_ENABLE: begin
          isc_en_q <= 1'b1;
          ext_en_q <= dr_sh_q[0];
          od_q     <= dr_sh_q[1];
        end
        `IR_ISC_DISABLE: begin
          isc_en_q <= 1'b0;
          ext_en_q <= 1'b0;
        end
        `IR_CLEAR_ERR: if (isc_en_q) clr_tgl_q <= ~clr_tgl_q;
        default: begin
          if (isc_en_q && !pending && ir_to_op(ir_q) != OP_NONE) begin
            lk_op_q      <= ir_to_op(ir_q);
            lk_operand_q <= dr_sh_q;
            req_tgl_q    <= ~req_tgl_q;
          end
        end
      endcase
    end
  end

  always_ff @(negedge tck_i or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      tdo_q <= 1'b0;
    end else if (tap_q == TAP_SHIFT_IR) begin
      tdo_q <= ir_sh_q[0];
    end else if (tap_q == TAP_SHIFT_DR) begin
      tdo_q <= (ir_q == `IR_BYPASS || ir_to_op(ir_q) == OP_NONE && ir_q != `IR_STATUS) ? byp_q : dr_sh_q[0];
    end
  end

  // ---
  // port e pin mux
  // ---
  logic flash_error_out;
  logic ext_on;

  assign flash_status_out = ~(flash_busy_i | flash_abort_o | ex_q == EX_WAIT);
  assign flash_error_out  = ~err_q;
  assign ext_on           = pins_on & lk_s2_q[1];

  always_comb begin
    port_e_out_o = gpio_out_i;
    port_e_oe_o  = gpio_oe_i;
    if (pins_on) begin
      port_e_out_o[2:0]         = 3'h0;
      port_e_oe_o[2:0]          = 3'h0;
      port_e_out_o[`PE_DOUT_BIT] = tdo_q;
      port_e_oe_o[`PE_DOUT_BIT]  = lk_s2_q[0] & (tap_q == TAP_SHIFT_DR || tap_q == TAP_SHIFT_IR);
    end
    if (ext_on) begin
      port_e_out_o[`PE_STAT_BIT] = lk_s2_q[2] ? 1'b0 : flash_status_out;
      port_e_oe_o[`PE_STAT_BIT]  = lk_s2_q[2] ? ~flash_status_out : 1'b1;
      port_e_out_o[`PE_ERR_BIT]  = lk_s2_q[2] ? 1'b0 : flash_error_out;
      port_e_oe_o[`PE_ERR_BIT]   = lk_s2_q[2] ? ~flash_error_out : 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** include/jtag_isp_consts.svh ***
// constants for the test port control block
`ifndef JTAG_ISP_CONSTS_SVH
`define JTAG_ISP_CONSTS_SVH

// register map, offsets inside the io block
`define RUN_ENABLE_OFS    8'hC7
`define RUN_ENABLE_BIT    0
`define RUN_PINS_ON_BIT   1
`define RUN_SECURED_BIT   2
`define RUN_ENABLE_RST    8'h00

// port e pin positions
`define PE_MODE_BIT       0
`define PE_CLK_BIT        1
`define PE_DIN_BIT        2
`define PE_DOUT_BIT       3
`define PE_STAT_BIT       4
`define PE_ERR_BIT        5

// instruction codes, 4-bit instruction register
`define IR_LEN            4
`define IR_CAPTURE        4'h1
`define IR_ISC_ENABLE     4'h1
`define IR_ISC_DISABLE    4'h2
`define IR_CLEAR_ERR      4'h3
`define IR_PROGRAM        4'h4
`define IR_ERASE          4'h5
`define IR_CHIP_ERASE     4'h6
`define IR_READ           4'h7
`define IR_VERIFY         4'h8
`define IR_STATUS         4'h9
`define IR_BYPASS         4'hF
`define DR_LEN            32

// flash abort window after reset
`define ABORT_TIME_US     25
`define CORE_CLK_MHZ      10
`define ABORT_CYC         (`ABORT_TIME_US * `CORE_CLK_MHZ)

`endif

// *** include/jtag_isp_pkg.sv ***
// types for the test port control block
package jtag_isp_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_type;

  typedef enum logic [2:0] {
    OP_NONE, OP_PROGRAM, OP_ERASE, OP_CHIP_ERASE, OP_READ, OP_VERIFY
  } isc_op_type;

  typedef enum logic {
    EX_IDLE, EX_WAIT
  } exec_state_type;

endpackage

// *** verification/jtag_isp_port_control_monitor.sv ***
// assertion checker for the test port control block
`timescale 1ns/10ps
`default_nettype none
`include "jtag_isp_consts.svh"

module jtag_isp_port_control_monitor (
  input wire logic       core_clk_i,
  input wire logic       arst_n_i,
  input wire logic       mcu_io_sel_i,
  input wire logic [7:0] mcu_addr_i,
  input wire logic       mcu_wr_i,
  input wire logic       mcu_rd_i,
  input wire logic [7:0] mcu_wdata_i,
  input wire logic [7:0] mcu_rdata_o,
  input wire logic       nvm_test_dedicate_i,
  input wire logic       test_select_term_i,
  input wire logic       flash_req_o,
  input wire logic       flash_done_i,
  input wire logic       flash_fail_i,
  input wire logic       flash_busy_i,
  input wire logic       flash_abort_o,
  input wire logic [5:0] port_e_out_o,
  input wire logic [5:0] port_e_oe_o,
  input wire logic [5:0] gpio_out_i,
  input wire logic [5:0] gpio_oe_i,
  input wire logic       test_pins_on_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  logic [8:0] abort_cnt_q;
  logic       wbit;

  assign wbit = mcu_wdata_i[`RUN_ENABLE_BIT];

  // saturates so a stuck abort still trips the bound below
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      abort_cnt_q <= 9'h000;
    end else if (flash_abort_o && abort_cnt_q != 9'h1FF) begin
      abort_cnt_q <= abort_cnt_q + 9'h001;
    end
  end

  sequence s_busy;
    flash_busy_i ##1 flash_busy_i;
  endsequence
  sequence s_ready;
    (!flash_busy_i && !flash_abort_o && !flash_req_o) [*2];
  endsequence

  property p_term_on;
    test_select_term_i |-> test_pins_on_o;
  endproperty
  a_term_on: assert property (p_term_on) else $error("term enable");
  property p_nvm_on;
    nvm_test_dedicate_i |-> test_pins_on_o;
  endproperty
  a_nvm_on: assert property (p_nvm_on) else $error("nvm enable");
  property p_run_write;
    mcu_io_sel_i && mcu_wr_i && mcu_addr_i == `RUN_ENABLE_OFS
      |=> test_pins_on_o == ($past(wbit) || nvm_test_dedicate_i || test_select_term_i);
  endproperty
  a_run_write: assert property (p_run_write) else $error("run enable write");
  property p_read_void;
    mcu_io_sel_i && mcu_rd_i && mcu_addr_i != `RUN_ENABLE_OFS |=> mcu_rdata_o == 8'h00;
  endproperty
  a_read_void: assert property (p_read_void) else $error("unmapped read");
  property p_off_gpio;
    !test_pins_on_o |-> port_e_oe_o[3:0] == gpio_oe_i[3:0]
      && (port_e_out_o[3:0] & gpio_oe_i[3:0]) == (gpio_out_i[3:0] & gpio_oe_i[3:0]);
  endproperty
  a_off_gpio: assert property (p_off_gpio) else $error("gpio pass");
  property p_inputs;
    test_pins_on_o |-> port_e_oe_o[2:0] == 3'h0;
  endproperty
  a_inputs: assert property (p_inputs) else $error("input driven");
  property p_abort_rel;
    $rose(arst_n_i) |-> flash_abort_o;
  endproperty
  a_abort_rel: assert property (p_abort_rel) else $error("abort at release");
  property p_abort_len;
    $fell(flash_abort_o) |-> abort_cnt_q >= 9'h0F9 && abort_cnt_q <= 9'h0FB;
  endproperty
  a_abort_len: assert property (p_abort_len) else $error("abort length");
  property p_abort_max;
    flash_abort_o |-> abort_cnt_q < 9'h0FB;
  endproperty
  a_abort_max: assert property (p_abort_max) else $error("abort too long");
  property p_no_req;
    flash_abort_o |-> !flash_req_o;
  endproperty
  a_no_req: assert property (p_no_req) else $error("request in abort");
  property p_err_fail;
    flash_done_i && flash_fail_i && !gpio_oe_i[5] && port_e_oe_o[5] && port_e_out_o[5]
      |-> ##[1:2] (port_e_oe_o[5] && !port_e_out_o[5]);
  endproperty
  a_err_fail: assert property (p_err_fail) else $error("error pin");
  property p_stat_busy;
    s_busy |-> gpio_oe_i[4] || !port_e_oe_o[4] || !port_e_out_o[4];
  endproperty
  a_stat_busy: assert property (p_stat_busy) else $error("status busy");
  property p_stat_ready;
    s_ready |-> gpio_oe_i[4] || !port_e_oe_o[4] || port_e_out_o[4];
  endproperty
  a_stat_ready: assert property (p_stat_ready) else $error("status ready");
endmodule

bind jtag_isp_port_control jtag_isp_port_control_monitor jtag_isp_port_control_monitor_i (
  .core_clk_i, .arst_n_i, .mcu_io_sel_i, .mcu_addr_i, .mcu_wr_i, .mcu_rd_i, .mcu_wdata_i,
  .mcu_rdata_o, .nvm_test_dedicate_i, .test_select_term_i, .flash_req_o, .flash_done_i,
  .flash_fail_i, .flash_busy_i, .flash_abort_o, .port_e_out_o, .port_e_oe_o, .gpio_out_i,
  .gpio_oe_i, .test_pins_on_o
);
`default_nettype wire

// *** verification/tap_host.sv ***
// behavioural external test controller for the serial test port
`timescale 1ns/10ps
`default_nettype none

module tap_host (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      cable_en_o,
  input  wire logic tdo_i
);
  initial begin
    {tck_o, tms_o, tdi_o, cable_en_o} = 4'h4;
  end

  // tck stands low between frames
  task automatic step(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #80 q = tdo_i;
    tck_o = 1'b1;
    #80 tck_o = 1'b0;
  endtask

  task automatic tap_reset();
    logic q;
    cable_en_o = 1'b1;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  // one ir or dr scan from idle back to idle, lsb first
  task automatic scan(input logic is_ir, input logic [31:0] v, output logic [31:0] cap);
    logic q;
    int   n;
    n = is_ir ? 4 : 32;
    cap = 32'h0;
    step(1'b1, 1'b0, q);
    if (is_ir) begin
      step(1'b1, 1'b0, q);
    end
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], q);
      cap[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    // stale data never looks like a held value
    tdi_o = ~tdi_o;
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// self-checking testbench for the test port control block
`timescale 1ns/10ps
`default_nettype none
`include "jtag_isp_consts.svh"

module tb import jtag_isp_pkg::*;;
  logic        core_clk_i, arst_n_i, mcu_io_sel_i, mcu_wr_i, mcu_rd_i;
  logic        nvm_test_dedicate_i, security_bit_i, term_rand, fail_next;
  logic        tck_i, tms, tdi, cable_en, test_select_term_i, flash_req_o, flash_abort_o, test_pins_on_o;
  logic        flash_busy_i = 1'b0, flash_done_i = 1'b0, flash_fail_i = 1'b0;
  logic [7:0]  flash_rdata_i = 8'h00;
  logic [7:0]  mcu_addr_i, mcu_wdata_i, mcu_rdata_o, flash_wdata_o, rd;
  logic [11:0] sector_protect_i;
  logic [5:0]  port_e_in_i, port_e_out_o, port_e_oe_o, gpio_out_i, gpio_oe_i, gpio_in_o;
  logic [19:0] flash_addr_o;
  logic [1:0]  flash_target_o;
  logic [3:0]  left_q;
  logic [31:0] cap, v;
  logic [3:0]  blocked [4] = '{`IR_PROGRAM, `IR_ERASE, `IR_READ, `IR_VERIFY};
  isc_op_type  flash_op_o;
  int          bad_count = 0, comparisons = 0, req_count = 0, seed;

  assign test_select_term_i = term_rand | cable_en;
  // pins 3..5 pulled up when nobody drives them
  assign port_e_in_i = (port_e_oe_o & port_e_out_o) | (~port_e_oe_o & {3'b111, tdi, tck_i, tms});

  always #50 core_clk_i = ~core_clk_i;

  jtag_isp_port_control jtag_isp_port_control_i (
    .core_clk_i, .arst_n_i, .tck_i, .mcu_io_sel_i, .mcu_addr_i, .mcu_wr_i, .mcu_rd_i, .mcu_wdata_i,
    .mcu_rdata_o, .nvm_test_dedicate_i, .test_select_term_i, .security_bit_i, .sector_protect_i,
    .flash_req_o, .flash_op_o, .flash_target_o, .flash_addr_o, .flash_wdata_o, .flash_done_i,
    .flash_fail_i, .flash_rdata_i, .flash_busy_i, .flash_abort_o, .port_e_in_i, .port_e_out_o,
    .port_e_oe_o, .gpio_out_i, .gpio_oe_i, .gpio_in_o, .test_pins_on_o
  );
  tap_host tap_host_i (.tck_o(tck_i), .tms_o(tms), .tdi_o(tdi), .cable_en_o(cable_en), .tdo_i(port_e_in_i[3]));

  // ---
  // flash engine stand-in, random latency
  // ---
  always @(negedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {flash_busy_i, flash_done_i, flash_fail_i, left_q} <= 7'h00;
    end else begin
      flash_done_i <= 1'b0;
      flash_fail_i <= 1'b0;
      if (flash_req_o) begin
        req_count <= req_count + 1;
        flash_busy_i <= 1'b1;
        left_q <= 4'h2 + 4'($random(seed) & 7);
      end else if (flash_busy_i && left_q == 4'h0) begin
        {flash_busy_i, flash_done_i, flash_fail_i} <= {2'b01, fail_next};
        flash_rdata_i <= 8'($random(seed));
      end else if (flash_busy_i) begin
        left_q <= left_q - 4'h1;
      end
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic mcu_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    {mcu_io_sel_i, mcu_wr_i, mcu_addr_i, mcu_wdata_i} = {2'b11, a, d};
    @(negedge core_clk_i);
    {mcu_io_sel_i, mcu_wr_i} = 2'b00;
  endtask

  task automatic mcu_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    {mcu_io_sel_i, mcu_rd_i, mcu_addr_i} = {2'b11, a};
    @(negedge core_clk_i);
    {mcu_io_sel_i, mcu_rd_i} = 2'b00;
    d = mcu_rdata_o;
  endtask

  task automatic do_reset();
    logic q;
    @(negedge core_clk_i);
    arst_n_i = 1'b0;
    fork
      repeat (2) @(negedge core_clk_i);
      tap_host_i.step(1'b1, 1'b0, q);
    join
    chk("abort in reset", 1, flash_abort_o);
    arst_n_i = 1'b1;
  endtask

  task automatic run_op(input logic [3:0] c, input logic [31:0] d, input logic f, input int n);
    int n0;
    n0 = req_count;
    fail_next = f;
    tap_host_i.scan(1'b1, {28'h0, c}, cap);
    tap_host_i.scan(1'b0, d, cap);
    repeat (40) @(negedge core_clk_i);
    chk("flash requests", n, req_count - n0);
  endtask

  initial begin
    #2000000;
    bad_count++;
    complete_run();
  end

  initial begin
    {core_clk_i, arst_n_i, mcu_io_sel_i, mcu_wr_i, mcu_rd_i, nvm_test_dedicate_i} = 6'h00;
    {security_bit_i, term_rand, fail_next, mcu_addr_i, mcu_wdata_i} = 19'h00000;
    {gpio_out_i, gpio_oe_i, sector_protect_i} = 24'h000000;
    seed = 32'h211D653B;
    do_reset();
    mcu_rd(`RUN_ENABLE_OFS, rd);
    chk("run reset", 8'h00, rd);
    mcu_rd(8'h10, rd);
    chk("unmapped read", 8'h00, rd);
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      mcu_wr(`RUN_ENABLE_OFS, v[7:0]);
      {term_rand, gpio_out_i, gpio_oe_i} = {v[8], v[21:16], v[29:24]};
      @(negedge core_clk_i);
      chk("pins on", v[0] | v[8], test_pins_on_o);
      if (!(v[0] | v[8])) chk("gpio enables", gpio_oe_i, port_e_oe_o);
      mcu_rd(`RUN_ENABLE_OFS, rd);
      chk("run read", {6'h00, v[0] | v[8], v[0]}, rd);
    end
    {term_rand, gpio_oe_i} = 7'h00;
    mcu_wr(`RUN_ENABLE_OFS, 8'hFE);
    mcu_rd(`RUN_ENABLE_OFS, rd);
    chk("run cleared", 8'h00, rd);
    nvm_test_dedicate_i = 1'b1;
    @(negedge core_clk_i);
    chk("nvm pins on", 1, test_pins_on_o);
    nvm_test_dedicate_i = 1'b0;
    repeat (260) @(negedge core_clk_i);
    tap_host_i.tap_reset();
    tap_host_i.scan(1'b1, {28'h0, `IR_ISC_ENABLE}, cap);
    chk("tdo idle", 32'hF, cap);
    chk("ext early", 2'b00, port_e_oe_o[5:4]);
    tap_host_i.scan(1'b0, 32'h1, cap);
    repeat (10) @(negedge core_clk_i);
    chk("pin enables", 6'h30, port_e_oe_o);
    chk("ext levels", 2'b11, port_e_out_o[5:4]);
    tap_host_i.scan(1'b1, {28'h0, `IR_STATUS}, cap);
    chk("capture ir", 32'h1, cap);
    for (int t = 0; t < 4; t++) begin
      v = $random(seed);
      v[31:28] = {2'b00, 2'(t)};
      run_op(`IR_PROGRAM, v, 1'b0, 1);
      chk("op", OP_PROGRAM, flash_op_o);
      chk("target", v[29:28], flash_target_o);
      chk("addr", v[27:8], flash_addr_o);
      chk("data", v[7:0], flash_wdata_o);
    end
    run_op(4'hA, v, 1'b0, 0);
    run_op(`IR_PROGRAM, v, 1'b1, 1);
    chk("error pin", 0, port_e_out_o[5]);
    run_op(`IR_PROGRAM, v, 1'b0, 1);
    chk("error held", 0, port_e_out_o[5]);
    run_op(`IR_CLEAR_ERR, 32'h0, 1'b0, 0);
    chk("error cleared", 1, port_e_out_o[5]);
    sector_protect_i = 12'h005;
    run_op(`IR_ERASE, 32'h2, 1'b0, 0);
    run_op(`IR_ERASE, 32'h1, 1'b0, 1);
    chk("erase op", OP_ERASE, flash_op_o);
    // abort a running program, coming back secured
    security_bit_i = 1'b1;
    tap_host_i.scan(1'b1, {28'h0, `IR_PROGRAM}, cap);
    tap_host_i.scan(1'b0, v, cap);
    for (int i = 0; i < 40 && !flash_busy_i; i++) @(negedge core_clk_i);
    do_reset();
    mcu_rd(`RUN_ENABLE_OFS, rd);
    chk("secured read", 8'h06, rd);
    repeat (260) @(negedge core_clk_i);
    chk("abort over", 0, flash_abort_o);
    tap_host_i.tap_reset();
    run_op(`IR_ISC_ENABLE, 32'h3, 1'b0, 0);
    chk("od idle", 2'b00, port_e_oe_o[5:4]);
    for (int i = 0; i < 4; i++) run_op(blocked[i], 32'h1, 1'b0, 0);
    chk("od error", 2'b10, {port_e_oe_o[5], port_e_out_o[5]});
    run_op(`IR_CHIP_ERASE, 32'h0, 1'b0, 1);
    chk("chip erase op", OP_CHIP_ERASE, flash_op_o);
    mcu_rd(`RUN_ENABLE_OFS, rd);
    chk("unsecured", 8'h02, rd);
    run_op(`IR_PROGRAM, v, 1'b0, 1);
    complete_run();
  end
endmodule
`default_nettype wire
